// ===== design/nce_core.sv
`timescale 1ns/10ps
module nce_core (
  // clock, reset, enable
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  // program memory
  output logic [9:0]             o_rom_addr,
  input  wire logic [7:0]        i_rom_data,
  // data memory pointer
  output logic [5:0]             o_ram_addr,
  input  wire logic [3:0]        i_ram_data,
  input  wire logic              i_ptr_load,
  input  wire logic [5:0]        i_ptr_value,
  // interrupt
  input  wire logic              i_int_n,
  input  wire logic              i_int_enable,
  output logic                   o_int_en_clr,
  // state view
  output nce_pkg::nce_arch_t     o_arch,
  output logic [7:0]             o_l_latch,
  output logic                   o_skip
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  nce_pkg::nce_arch_t arch;
  nce_pkg::nce_state_t state;
  nce_pkg::nce_state_t next_state;
  logic [9:0]  ret_stack [0:nce_pkg::STACK_DEPTH-1];
  logic [9:0]  rom_addr;
  logic [5:0]  ptr;
  logic [7:0]  latch;
  logic [7:0]  first;
  logic        skip;
  logic        int_s1;
  logic        int_s2;
  logic        int_s3;
  logic        int_pend;
  logic        int_clr;

  logic [9:0]  next_pc;
  logic [9:0]  next_addr;
  logic [3:0]  next_acc;
  logic        next_carry;
  logic        next_skip;
  logic        next_latch_ld;
  logic [7:0]  next_latch;
  logic        push;
  logic        pop;
  logic [9:0]  push_val;

  logic [7:0]  op;
  logic [9:0]  pc_inc;
  logic [4:0]  sum_asc;
  logic [4:0]  sum_complement_add_carry_skip;
  logic [4:0]  sum_imm;
  logic [3:0]  sum_add;
  logic [3:0]  sum_ten;
  logic        take_int;
  logic        exec;

  function automatic logic is_two_byte(input logic [7:0] b);
    is_two_byte = (b == nce_pkg::OP_EXT_PFX) || (b == nce_pkg::OP_DIRECT_PFX) ||
                  (b[7:2] == nce_pkg::LONG_JUMP_HI) || (b[7:2] == nce_pkg::LONG_CALL_HI);
  endfunction

  assign op       = i_rom_data;
  assign pc_inc   = arch.pc + 10'h001;
  assign sum_asc  = {1'b0, arch.acc} + {1'b0, i_ram_data} + {4'h0, arch.carry};
  assign sum_complement_add_carry_skip = {1'b0, ~arch.acc} + {1'b0, i_ram_data} + {4'h0, arch.carry};
  assign sum_imm  = {1'b0, arch.acc} + {1'b0, op[3:0]};
  assign sum_add  = arch.acc + i_ram_data;
  assign sum_ten  = arch.acc + nce_pkg::TEN_VALUE;
  assign take_int = int_pend && i_int_enable && !skip && (state == nce_pkg::S_FETCH);
  assign exec     = i_ce && (state == nce_pkg::S_FETCH) && !skip && !take_int;

  assign o_arch       = arch;
  assign o_rom_addr   = rom_addr;
  assign o_ram_addr   = ptr;
  assign o_l_latch    = latch;
  assign o_skip       = skip;
  assign o_int_en_clr = int_clr;

  // ---------------------------------------------------------------
  // execution
  // ---------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_pc       = arch.pc;
    next_addr     = rom_addr;
    next_acc      = arch.acc;
    next_carry    = arch.carry;
    next_skip     = skip;
    next_latch_ld = 1'b0;
    next_latch    = latch;
    push          = 1'b0;
    pop           = 1'b0;
    push_val      = pc_inc;
    unique case (state)
      nce_pkg::S_FETCH: begin
        next_pc   = pc_inc;
        if (take_int) begin
          push     = 1'b1;
          push_val = arch.pc;
          next_pc  = nce_pkg::INT_VECTOR;
        end else if (skip) begin
          next_skip = 1'b0;
          if (is_two_byte(op)) begin
            next_state = nce_pkg::S_SKIP2;
          end
        end else if (is_two_byte(op)) begin
          next_state = nce_pkg::S_SECOND;
        end else if (op == nce_pkg::OP_IND_JUMP) begin
          next_pc    = arch.pc;
          next_state = nce_pkg::S_IND;
        end else if (op[7] && (op != nce_pkg::OP_LOAD_Q_IND)) begin
          if (arch.pc[9:7] == nce_pkg::SUB_PAGES_HI) begin
            next_pc = {arch.pc[9:7], op[6:0]};
          end else if (op[6]) begin
            next_pc = {arch.pc[9:6], op[5:0]};
          end else begin
            push    = 1'b1;
            next_pc = {nce_pkg::CALL_PAGE_HI, op[5:0]};
          end
        end else if (op[7:4] == nce_pkg::OP_ADD_IMM_HI) begin
          if (op[3:0] != 4'h0) begin
            next_acc  = sum_imm[3:0];
            next_skip = sum_imm[4];
          end
        end else begin
          unique case (op)
            nce_pkg::OP_ADD_C_SKIP: begin
              {next_carry, next_acc} = sum_asc;
              next_skip = sum_asc[4];
            end
            nce_pkg::OP_CPL_ADD_C: begin
              {next_carry, next_acc} = sum_complement_add_carry_skip;
              next_skip = sum_complement_add_carry_skip[4];
            end
            nce_pkg::OP_ADD:       next_acc = sum_add;
            nce_pkg::OP_ADD_TEN:   next_acc = sum_ten;
            nce_pkg::OP_ZERO_ACC:  next_acc = nce_pkg::ACC_RESET;
            nce_pkg::OP_INVERT_ACC: next_acc = ~arch.acc;
            nce_pkg::OP_XOR:       next_acc = arch.acc ^ i_ram_data;
            nce_pkg::OP_CLR_CARRY: next_carry = 1'b0;
            nce_pkg::OP_SET_CARRY: next_carry = 1'b1;
            nce_pkg::OP_POP_RESUME: begin
              pop     = 1'b1;
              next_pc = ret_stack[0];
            end
            nce_pkg::OP_POP_SKIP: begin
              pop       = 1'b1;
              next_pc   = ret_stack[0];
              next_skip = 1'b1;
            end
            default: ;
          endcase
        end
        next_addr = next_pc;
        if (next_state == nce_pkg::S_IND) begin
          next_addr = {arch.pc[9:8], arch.acc, i_ram_data};
        end
      end
      nce_pkg::S_SECOND: begin
        next_state = nce_pkg::S_FETCH;
        next_pc    = pc_inc;
        if (first[7:2] == nce_pkg::LONG_JUMP_HI) begin
          next_pc = {first[1:0], op};
        end else if (first[7:2] == nce_pkg::LONG_CALL_HI) begin
          push    = 1'b1;
          next_pc = {first[1:0], op};
        end else if ((first == nce_pkg::OP_EXT_PFX) && (op == nce_pkg::COPY_LATCH_2ND)) begin
          next_latch_ld = 1'b1;
          next_latch    = op;
          next_state    = nce_pkg::S_LATCH;
        end
        next_addr = next_pc;
      end
      nce_pkg::S_LATCH: begin
        next_latch_ld = 1'b1;
        next_latch    = {arch.acc, i_ram_data};
        next_state    = nce_pkg::S_FETCH;
      end
      nce_pkg::S_IND: begin
        next_pc    = {arch.pc[9:8], op};
        next_addr  = next_pc;
        next_state = nce_pkg::S_FETCH;
      end
      nce_pkg::S_SKIP2: begin
        next_pc    = pc_inc;
        next_addr  = pc_inc;
        next_state = nce_pkg::S_FETCH;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      arch     <= '{pc: nce_pkg::PC_RESET, acc: nce_pkg::ACC_RESET, carry: 1'b0};
      rom_addr <= nce_pkg::PC_RESET;
      state    <= nce_pkg::S_FETCH;
      skip     <= 1'b0;
      first    <= 8'h00;
    end else if (i_ce) begin
      arch     <= '{pc: next_pc, acc: next_acc, carry: next_carry};
      rom_addr <= next_addr;
      state    <= next_state;
      skip     <= next_skip;
      first    <= op;
    end
  end

  // ---------------------------------------------------------------
  // return stack, ram pointer, output latch
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < nce_pkg::STACK_DEPTH; i++) begin
        ret_stack[i] <= nce_pkg::PC_RESET;
      end
    end else if (i_ce && push) begin
      ret_stack[0] <= push_val;
      for (int i = 1; i < nce_pkg::STACK_DEPTH; i++) begin
        ret_stack[i] <= ret_stack[i-1];
      end
    end else if (i_ce && pop) begin
      for (int i = 0; i < nce_pkg::STACK_DEPTH - 1; i++) begin
        ret_stack[i] <= ret_stack[i+1];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr   <= nce_pkg::PTR_RESET;
      latch <= nce_pkg::LATCH_RESET;
    end else if (i_ce) begin
      if (i_ptr_load) begin
        ptr <= i_ptr_value;
      end
      if (next_latch_ld) begin
        latch <= next_latch;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      int_s1   <= 1'b1;
      int_s2   <= 1'b1;
      int_s3   <= 1'b1;
      int_pend <= 1'b0;
      int_clr  <= 1'b0;
    end else if (i_ce) begin
      int_s1  <= i_int_n;
      int_s2  <= int_s1;
      int_s3  <= int_s2;
      int_clr <= take_int;
      // a new falling edge beats the acknowledge
      if (int_s3 && !int_s2) begin
        int_pend <= 1'b1;
      end else if (take_int) begin
        int_pend <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  AST_ADD_C_SKIP: assert property (exec && op == nce_pkg::OP_ADD_C_SKIP |=>
    {arch.carry, arch.acc} == $past(sum_asc) && skip == arch.carry)
    else $error("add with carry result or skip wrong");
  AST_ADD_PLAIN: assert property (exec && op == nce_pkg::OP_ADD |=>
    arch.acc == $past(sum_add) && arch.carry == $past(arch.carry) && !skip)
    else $error("plain add wrong");
  AST_ADD_IMM: assert property (exec && op[7:4] == nce_pkg::OP_ADD_IMM_HI &&
    op[3:0] != 4'h0 |=> skip == $past(sum_imm[4]) && arch.carry == $past(arch.carry))
    else $error("immediate add skip wrong");
  AST_ZERO_ACC: assert property (exec && op == nce_pkg::OP_ZERO_ACC |=>
    arch.acc == 4'h0 && !skip)
    else $error("accumulator not cleared");
  AST_SET_CARRY: assert property (exec && op == nce_pkg::OP_SET_CARRY |=>
    arch.carry && !skip)
    else $error("carry not set");
  AST_PAGE_CALL: assert property (exec && op[7:6] == 2'b10 && op != nce_pkg::OP_LOAD_Q_IND &&
    arch.pc[9:7] != nce_pkg::SUB_PAGES_HI |=> arch.pc[9:6] == nce_pkg::CALL_PAGE_HI &&
    ret_stack[0] == $past(pc_inc) && ret_stack[1] == $past(ret_stack[0]))
    else $error("page two call wrong");
  AST_POP: assert property (exec && op == nce_pkg::OP_POP_RESUME |=>
    arch.pc == $past(ret_stack[0]) && ret_stack[0] == $past(ret_stack[1]) && !skip)
    else $error("return pop wrong");
  AST_POP_SKIP: assert property (exec && op == nce_pkg::OP_POP_SKIP |=> skip)
    else $error("skip after return missing");
  AST_IND_TWO: assert property (exec && op == nce_pkg::OP_IND_JUMP |=>
    state == nce_pkg::S_IND && arch.pc == $past(arch.pc))
    else $error("indirect jump not two cycles");
  AST_INT_TAKE: assert property (i_ce && take_int |=>
    arch.pc == nce_pkg::INT_VECTOR && o_int_en_clr && ret_stack[0] == $past(arch.pc))
    else $error("interrupt entry wrong");
  AST_SKIPPED: assert property (i_ce && state == nce_pkg::S_FETCH && skip &&
    !is_two_byte(op) |=> !skip && arch.acc == $past(arch.acc) && arch.pc == $past(pc_inc))
    else $error("skipped instruction changed state");
  AST_LATCH_GLITCH: assert property (i_ce && state == nce_pkg::S_SECOND &&
    first == nce_pkg::OP_EXT_PFX && op == nce_pkg::COPY_LATCH_2ND |=> latch == 8'h3c)
    else $error("latch did not show second byte");

endmodule

// ===== design/nce_pkg.sv
package nce_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ZERO_ACC    = 8'h00;
  localparam logic [7:0] OP_XOR         = 8'h02;
  localparam logic [7:0] OP_CPL_ADD_C   = 8'h10;
  localparam logic [7:0] OP_SET_CARRY   = 8'h22;
  localparam logic [7:0] OP_DIRECT_PFX  = 8'h23;
  localparam logic [7:0] OP_ADD_C_SKIP  = 8'h30;
  localparam logic [7:0] OP_ADD         = 8'h31;
  localparam logic [7:0] OP_CLR_CARRY   = 8'h32;
  localparam logic [7:0] OP_EXT_PFX     = 8'h33;
  localparam logic [7:0] OP_INVERT_ACC  = 8'h40;
  localparam logic [7:0] OP_IDLE        = 8'h44;
  localparam logic [7:0] OP_POP_RESUME  = 8'h48;
  localparam logic [7:0] OP_POP_SKIP    = 8'h49;
  localparam logic [7:0] OP_ADD_TEN     = 8'h4a;
  localparam logic [7:0] OP_LOAD_Q_IND  = 8'hbf;
  localparam logic [7:0] OP_IND_JUMP    = 8'hff;
  localparam logic [7:0] COPY_LATCH_2ND = 8'h3c;
  localparam logic [3:0] OP_ADD_IMM_HI  = 4'h5;
  localparam logic [5:0] LONG_JUMP_HI   = 6'b011000;
  localparam logic [5:0] LONG_CALL_HI   = 6'b011010;

  // ---------------------------------------------------------------
  // constants and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] TEN_VALUE      = 4'ha;
  localparam logic [3:0] CALL_PAGE_HI   = 4'h2;
  localparam logic [2:0] SUB_PAGES_HI   = 3'h1;
  localparam logic [9:0] PC_RESET       = 10'h000;
  localparam logic [9:0] INT_VECTOR     = 10'h0ff;
  localparam logic [3:0] ACC_RESET      = 4'h0;
  localparam logic [5:0] PTR_RESET      = 6'h00;
  localparam logic [7:0] LATCH_RESET    = 8'h00;
  localparam int         STACK_DEPTH    = 3;

  typedef struct packed {
    logic [9:0] pc;
    logic [3:0] acc;
    logic       carry;
  } nce_arch_t;

  typedef enum {
    S_FETCH,
    S_SECOND,
    S_SKIP2,
    S_IND,
    S_LATCH
  } nce_state_t;

endpackage

// ===== verification/nibble_core_arith_branch_exec_test.sv
`timescale 1ns/10ps
module nibble_core_arith_branch_exec_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct {
    string       name;
    logic [14:0] exp;
  } nce_tb_note_t;
  logic               i_mclk       = 1'b0;
  logic               i_nrst       = 1'b0;
  logic               i_ce         = 1'b1;
  logic               i_ptr_load   = 1'b0;
  logic [5:0]         i_ptr_value  = 6'h00;
  logic               i_int_n      = 1'b1;
  logic               i_int_enable = 1'b0;
  logic [9:0]         o_rom_addr;
  logic [7:0]         i_rom_data;
  logic [5:0]         o_ram_addr;
  logic [3:0]         i_ram_data;
  logic               o_int_en_clr;
  nce_pkg::nce_arch_t o_arch;
  logic [7:0]         o_l_latch;
  logic               o_skip;
  logic [7:0]         rom [1024];
  logic [3:0]         ram [64];
  logic [7:0]         ops [11];
  nce_tb_note_t       notes [$];
  int                 fail_count   = 0;
  int                 checks_done  = 0;
  logic               saw_3c       = 1'b0;
  logic               saw_vec      = 1'b0;
  logic [3:0]         pulses       = 4'h0;

  always #2.5 i_mclk = ~i_mclk;
  // memories answer combinationally, as the core expects
  assign i_rom_data = rom[o_rom_addr];
  assign i_ram_data = ram[o_ram_addr];

  nce_core uut (
    .i_mclk       (i_mclk),
    .i_nrst       (i_nrst),
    .i_ce         (i_ce),
    .o_rom_addr   (o_rom_addr),
    .i_rom_data   (i_rom_data),
    .o_ram_addr   (o_ram_addr),
    .i_ram_data   (i_ram_data),
    .i_ptr_load   (i_ptr_load),
    .i_ptr_value  (i_ptr_value),
    .i_int_n      (i_int_n),
    .i_int_enable (i_int_enable),
    .o_int_en_clr (o_int_en_clr),
    .o_arch       (o_arch),
    .o_l_latch    (o_l_latch),
    .o_skip       (o_skip)
  );

  // ---------------------------------------------------------------
  // observers and comparison
  // ---------------------------------------------------------------
  // latch lines are only sampled on the clock, never used as a clock
  always @(posedge i_mclk) begin
    if (o_l_latch === 8'h3c) saw_3c <= 1'b1;
    if (o_rom_addr === nce_pkg::INT_VECTOR) saw_vec <= 1'b1;
    // a pulse stays up through disabled cycles, so count it on enabled edges only
    if (o_int_en_clr === 1'b1 && i_ce === 1'b1) pulses <= pulses + 4'h1;
  end

  function automatic logic [14:0] observe(input string nm);
    case (nm)
      "ptr":    return {9'h000, o_ram_addr};
      "latch":  return {7'h00, o_l_latch};
      "saw3c":  return {14'h0000, saw_3c};
      "vec":    return {14'h0000, saw_vec};
      "pulses": return {11'h000, pulses};
      "skip":   return {14'h0000, o_skip};
      default:  return o_arch;
    endcase
  endfunction

  initial begin : monitor
    nce_tb_note_t n;
    logic [14:0]  got;
    forever begin
      @(negedge i_mclk);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        got = observe(n.name);
        checks_done++;
        if (got !== n.exp) begin
          fail_count++;
          $display("[ERR] %s expected %h seen %h", n.name, n.exp, got);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic expect_val(input string nm, input logic [14:0] v);
    notes.push_back('{nm, v});
  endtask

  task automatic clear_mem();
    foreach (rom[i]) rom[i] = nce_pkg::OP_IDLE;
    foreach (ram[i]) ram[i] = 4'h0;
  endtask

  task automatic start(input logic [5:0] p);
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    i_ce <= 1'b1;
    repeat (4) @(posedge i_mclk);
    saw_3c = 1'b0;
    saw_vec = 1'b0;
    pulses = 4'h0;
    i_nrst <= 1'b1;
    i_ptr_load <= 1'b1;
    i_ptr_value <= p;
    @(posedge i_mclk);
    i_ptr_load <= 1'b0;
  endtask

  // random clock-enable gaps stretch every sequence
  task automatic run(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      i_ce <= ($urandom_range(3) != 0);
    end
    @(posedge i_mclk);
    i_ce <= 1'b1;
    #1;
  endtask

  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin : watchdog
    #50000;
    fail_count++;
    test_done();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin : main
    logic [3:0] a, m, y, r;
    logic       c, nc, sk;
    logic [5:0] p;
    ops = '{8'h30, 8'h31, 8'h4a, 8'h50, 8'h10, 8'h00, 8'h40, 8'h44, 8'h32, 8'h22, 8'h02};
    void'($urandom(62875));
    // arithmetic: preset acc and carry, op, then an invert that a skip hides
    for (int k = 0; k < 33; k++) begin
      a = 4'($urandom_range(15));
      m = 4'($urandom_range(15));
      y = 4'($urandom_range(15, 1));
      c = 1'($urandom_range(1));
      p = 6'($urandom_range(63));
      clear_mem();
      rom[0] = (a == 4'h0) ? nce_pkg::OP_ZERO_ACC : {nce_pkg::OP_ADD_IMM_HI, a};
      rom[1] = c ? nce_pkg::OP_SET_CARRY : nce_pkg::OP_CLR_CARRY;
      rom[2] = (ops[k % 11] == 8'h50) ? {nce_pkg::OP_ADD_IMM_HI, y} : ops[k % 11];
      rom[3] = nce_pkg::OP_INVERT_ACC;
      rom[4] = 8'hc4;
      ram[p] = m;
      r = a;
      nc = c;
      sk = 1'b0;
      if (rom[2][7:4] == nce_pkg::OP_ADD_IMM_HI) {sk, r} = {1'b0, a} + y;
      case (rom[2])
        nce_pkg::OP_ADD_C_SKIP: {sk, r} = {1'b0, a} + m + c;
        nce_pkg::OP_CPL_ADD_C:  {sk, r} = {1'b0, ~a} + m + c;
        nce_pkg::OP_ADD:        r = a + m;
        nce_pkg::OP_ADD_TEN:    r = a + nce_pkg::TEN_VALUE;
        nce_pkg::OP_ZERO_ACC:   r = 4'h0;
        nce_pkg::OP_INVERT_ACC: r = ~a;
        nce_pkg::OP_CLR_CARRY:  nc = 1'b0;
        nce_pkg::OP_SET_CARRY:  nc = 1'b1;
        nce_pkg::OP_XOR:        r = a ^ m;
        default: ;
      endcase
      if (rom[2] == nce_pkg::OP_ADD_C_SKIP || rom[2] == nce_pkg::OP_CPL_ADD_C) nc = sk;
      start(p);
      run(20);
      expect_val("arch_alu", {10'h004, (sk ? r : ~r), nc});
      expect_val("ptr", {9'h000, p});
      expect_val("skip", 15'h0000);
    end
    // calls, paged jumps, returns, skipped two-byte op, indirect and long jump
    clear_mem();
    ram[0] = 4'h5;
    rom[0] = {nce_pkg::LONG_CALL_HI, 2'b01};
    rom[1] = 8'h20;
    rom[10'h120] = 8'h88;
    rom[10'h088] = 8'hd0;
    rom[10'h0d0] = nce_pkg::OP_POP_SKIP;
    rom[10'h121] = {nce_pkg::LONG_JUMP_HI, 2'b00};
    rom[10'h122] = 8'h5f;
    rom[10'h123] = nce_pkg::OP_POP_RESUME;
    rom[2] = 8'h52;
    rom[3] = nce_pkg::OP_IND_JUMP;
    rom[10'h025] = 8'h30;
    rom[10'h030] = {nce_pkg::LONG_JUMP_HI, 2'b10};
    rom[10'h031] = 8'h80;
    rom[10'h280] = 8'hc0;
    start(6'h00);
    run(50);
    expect_val("arch_flow", {10'h280, 4'h2, 1'b0});
    // four nested calls: the oldest return address falls off the stack
    clear_mem();
    rom[0] = {nce_pkg::LONG_CALL_HI, 2'b01};
    rom[1] = 8'h00;
    rom[10'h100] = {nce_pkg::LONG_CALL_HI, 2'b01};
    rom[10'h101] = 8'h04;
    rom[10'h104] = {nce_pkg::LONG_CALL_HI, 2'b01};
    rom[10'h105] = 8'h08;
    rom[10'h108] = {nce_pkg::LONG_CALL_HI, 2'b01};
    rom[10'h109] = 8'h0c;
    foreach (rom[i]) if (i inside {10'h10c, 10'h10a, 10'h106, 10'h102}) rom[i] = 8'h48;
    rom[10'h002] = 8'hc2;
    start(6'h00);
    run(50);
    expect_val("arch_stack", {10'h102, 4'h0, 1'b0});
    // copy to latch shows the second opcode byte before the data
    clear_mem();
    a = 4'($urandom_range(15, 4));
    m = 4'($urandom_range(15));
    ram[0] = m;
    rom[0] = {nce_pkg::OP_ADD_IMM_HI, a};
    rom[1] = nce_pkg::OP_EXT_PFX;
    rom[2] = nce_pkg::COPY_LATCH_2ND;
    rom[3] = 8'hc3;
    start(6'h00);
    run(20);
    expect_val("saw3c", 15'h0001);
    expect_val("latch", {7'h00, a, m});
    expect_val("arch_latch", {10'h003, a, 1'b0});
    // interrupt taken once, then ignored while enable is low
    clear_mem();
    rom[5] = 8'hc5;
    rom[10'h100] = nce_pkg::OP_POP_RESUME;
    start(6'h00);
    run(8);
    i_int_enable <= 1'b1;
    i_int_n <= 1'b0;
    run(12);
    i_int_enable <= 1'b0;
    i_int_n <= 1'b1;
    run(6);
    i_int_n <= 1'b0;
    run(12);
    i_int_n <= 1'b1;
    expect_val("pulses", 15'h0001);
    expect_val("vec", 15'h0001);
    expect_val("arch_int", {10'h005, 4'h0, 1'b0});
    run(2);
    test_done();
  end
endmodule
